/* hw/tcpc_defines.svh */
// Offsets, fields, resets and timing of the tap changer control block.
// Assumes a 32-bit Wishbone bus and a 200 MHz clock.
`ifndef TCPC_DEFINES_SVH
`define TCPC_DEFINES_SVH

// Register byte offsets
`define TCPC_REG_CTRL      8'h00
`define TCPC_REG_RAISE_PW  8'h04
`define TCPC_REG_LOWER_PW  8'h08
`define TCPC_REG_STOP_PW   8'h0c
`define TCPC_REG_SEL_TO    8'h10
`define TCPC_REG_EXE_TO    8'h14
`define TCPC_REG_CMD       8'h18
`define TCPC_REG_STATUS    8'h1c
`define TCPC_REG_IRQ_STAT  8'h20
`define TCPC_REG_IRQ_MASK  8'h24

// Control register fields
`define TCPC_CTRL_MODE_LSB   0
`define TCPC_CTRL_STOPEN_BIT 3
`define TCPC_CTRL_ANA_LSB    4
`define TCPC_CTRL_FIRST_LSB  8
`define TCPC_CTRL_LAST_LSB   16
`define TCPC_CTRL_MAX_LSB    24

// Command register bits
`define TCPC_CMD_SEL_RAISE 0
`define TCPC_CMD_SEL_LOWER 1
`define TCPC_CMD_EXECUTE   2
`define TCPC_CMD_CANCEL    3

// Reset values; times count 10 ms ticks
`define TCPC_RST_FIRST   6'd1
`define TCPC_RST_LAST    6'd13
`define TCPC_RST_ANA     3'd0
`define TCPC_RST_MAX     6'd39
`define TCPC_RST_PW      10'd20
`define TCPC_RST_TO      13'd3000
`define TCPC_PW_MAX      10'd1000
`define TCPC_TO_MIN      13'd1000
`define TCPC_TO_MAX      13'd6000
`define TCPC_MAX_POS_MIN 6'd1
`define TCPC_MAX_POS_MAX 6'd39

// Digit widths of the three binary modes
`define TCPC_W_TENS  6'd13
`define TCPC_W_SPLIT 6'd7
`define TCPC_W_BIN   6'd6

// Timing: one setting step is 10 ms
`define TCPC_CLK_NS      5
`define TCPC_TICK_NS     10000000
`define TCPC_TICK_CYCLES (`TCPC_TICK_NS / `TCPC_CLK_NS)
`define TCPC_TICK_W      24
`define TCPC_BI_MAX      32

`endif

/* hw/tcpc_pkg.sv */
// Types of the tap changer control block.
// Assumes tcpc_defines.svh.
`include "tcpc_defines.svh"

package tcpc_pkg;

   typedef enum logic [2:0] {
      MODE_TENS,
      MODE_SPLIT,
      MODE_BIN,
      MODE_ANALOG,
      MODE_NET
   } tcpc_mode_e;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SELECTED,
      ST_EXEC
   } tcpc_state_e;

   typedef struct packed {
      tcpc_mode_e  mode;
      logic        stop_en;
      logic [2:0]  ana_sel;
      logic [5:0]  first;
      logic [5:0]  last;
      logic [5:0]  max_pos;
      logic [9:0]  raise_pw;
      logic [9:0]  lower_pw;
      logic [9:0]  stop_pw;
      logic [12:0] sel_to;
      logic [12:0] exe_to;
   } tcpc_cfg_s;

   typedef struct packed {
      logic [`TCPC_BI_MAX-1:0] bin_s1;
      logic [`TCPC_BI_MAX-1:0] bin_s2;
      tcpc_cfg_s               cfg;
      tcpc_state_e             st;
      logic                    dir_raise;
      logic [6:0]              pos;
      logic                    pos_ok;
      logic                    pos_err;
      logic                    cfg_err;
      logic [`TCPC_TICK_W-1:0] tick_cnt;
      logic [9:0]              pulse_cnt;
      logic [12:0]             phase_cnt;
      logic                    step_seen;
      logic                    stop_busy;
      logic [9:0]              stop_cnt;
      logic                    raise;
      logic                    lower;
      logic                    stop;
      logic [5:0]              irq_stat;
      logic [5:0]              irq_mask;
      logic                    ack;
      logic [31:0]             rdat;
   } tcpc_regs_s;

endpackage

/* hw/tcpc_top.sv */
// Tap position decode, select-before-operate raise/lower, runaway stop.
// Assumes one 200 MHz clock and synchronous reset.
`timescale 1ns/100ps
`default_nettype none
`include "tcpc_defines.svh"

// Function
// (RQ1) Mode setting picks one of five sources
// (RQ2) Tens mode samples thirteen inputs, first LSB
// (RQ3) Tens bits 10/20/30 plus one-hot units
// (RQ4) Split mode: four binary units, three tens
// (RQ5) Six inputs read as plain binary
// (RQ6) Analog mode takes selected DC channel
// (RQ7) Maximum position 1..39 default 39, error above
// (RQ8) First input defaults 1, last 13
// (RQ9) Raise/lower only after successful select step
// (RQ10) Raise pulse 0..10 s, default 0.2 s
// (RQ11) Lower pulse 0..10 s, default 0.2 s
// (RQ12) Stop pulse 0..10 s, default 0.2 s
// (RQ13) Select cancelled after select timeout, 10..60 s
// (RQ14) Execute phase limited by timeout, expiry fails
// (RQ15) Runaway stop enable 0/1, default 0
// (RQ16) Runaway with enable pulses the stop output
// (RQ17) Runaway: unexpected or continued position change
// (RQ18) Never both outputs; reject command while pulsing
module tcpc_top
   import tcpc_pkg::*;
#(
   parameter int unsigned NUM_BI      = 32,
   parameter int unsigned NUM_ANA     = 6,
   parameter int unsigned TICK_CYCLES = `TCPC_TICK_CYCLES
) (
   input  wire logic                   clk_i,
   input  wire logic                   rst_i,
   input  wire logic [7:0]             adr_i,
   input  wire logic [31:0]            dat_i,
   output logic      [31:0]            dat_o,
   input  wire logic                   we_i,
   input  wire logic [3:0]             sel_i,
   input  wire logic                   cyc_i,
   input  wire logic                   stb_i,
   output logic                        ack_o,
   input  wire logic [NUM_BI-1:0]      bin_in_i,
   input  wire logic [NUM_ANA-1:0][5:0] ana_pos_i,
   input  wire logic [5:0]             net_pos_i,
   output logic                        raise_command_output_o,
   output logic                        lower_command_output_o,
   output logic                        emergency_stop_output_o,
   output logic                        irq_o
);

   if (NUM_BI < 13 || NUM_BI > `TCPC_BI_MAX) begin : g_bad_bi
      $error("NUM_BI must lie in 13..32");
   end
   if (NUM_ANA < 1 || NUM_ANA > 8) begin : g_bad_ana
      $error("NUM_ANA must lie in 1..8");
   end
   if (TICK_CYCLES < 3 || TICK_CYCLES >= (1 << `TCPC_TICK_W)) begin : g_bad_tick
      $error("TICK_CYCLES out of range");
   end

   localparam logic [`TCPC_TICK_W-1:0] TICK_LAST = `TCPC_TICK_W'(TICK_CYCLES - 1);

   tcpc_regs_s q;
   tcpc_regs_s d;

   ////////////////////////
   // Helpers

   function automatic logic [31:0] merge(input logic [31:0] cur,
                                         input logic [31:0] wd,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = cur;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [9:0] clamp_pw(input logic [31:0] v);
      return (v > 32'(`TCPC_PW_MAX)) ? `TCPC_PW_MAX : v[9:0];
   endfunction

   function automatic logic [12:0] clamp_to(input logic [31:0] v);
      logic [12:0] r;
      r = v[12:0];
      if (v > 32'(`TCPC_TO_MAX)) begin
         r = `TCPC_TO_MAX;
      end else if (v < 32'(`TCPC_TO_MIN)) begin
         r = `TCPC_TO_MIN;
      end
      return r;
   endfunction

   ////////////////////////
   // Next state

   logic [31:0] win;
   logic [6:0]  tens;
   logic [6:0]  units;
   logic [6:0]  pos_now;
   logic [5:0]  need;
   logic [5:0]  span;
   logic        digital;
   logic        tick;
   logic        chg;
   logic        runaway;
   logic        req;
   logic        wr;
   logic [31:0] wv;
   logic [31:0] ctrl_rd;
   logic [31:0] stat_rd;
   logic        c_sel_r;
   logic        c_sel_l;
   logic        c_exec;
   logic        c_cancel;
   logic        ev_rej;
   logic        ev_done;
   logic        ev_fail;
   logic        ev_selto;
   logic [5:0]  events;
   logic [5:0]  irq_clr;
   logic        pulse_act;

   always_comb begin
      d        = q;
      tens     = 7'd0;
      units    = 7'd0;
      pos_now  = 7'd0;
      need     = `TCPC_W_TENS;
      digital  = 1'b1;
      ev_rej   = 1'b0;
      ev_done  = 1'b0;
      ev_fail  = 1'b0;
      ev_selto = 1'b0;
      irq_clr  = 6'd0;
      wv       = 32'd0;

      // Two-flop synchroniser on the contacts
      d.bin_s1 = `TCPC_BI_MAX'(bin_in_i);
      d.bin_s2 = q.bin_s1;

      // 10 ms time base
      tick       = (q.tick_cnt == TICK_LAST);
      d.tick_cnt = tick ? '0 : q.tick_cnt + 1'b1;

      // Window starts at the first selected input
      win = q.bin_s2 >> (q.cfg.first - 6'd1); // RQ2
      case (q.cfg.mode) // RQ1
         MODE_TENS: begin
            need = `TCPC_W_TENS;
            tens = (win[0] ? 7'd10 : 7'd0) + (win[1] ? 7'd20 : 7'd0)
                 + (win[2] ? 7'd30 : 7'd0); // RQ3
            for (int i = 9; i >= 0; i--) begin
               if (win[3 + i]) begin
                  units = 7'(i); // RQ3
               end
            end
            pos_now = tens + units; // RQ3
         end
         MODE_SPLIT: begin
            need    = `TCPC_W_SPLIT;
            tens    = (win[4] ? 7'd10 : 7'd0) + (win[5] ? 7'd20 : 7'd0)
                    + (win[6] ? 7'd30 : 7'd0); // RQ4
            pos_now = tens + {3'd0, win[3:0]}; // RQ4
         end
         MODE_BIN: begin
            need    = `TCPC_W_BIN;
            pos_now = {1'b0, win[5:0]}; // RQ5
         end
         MODE_ANALOG: begin
            digital = 1'b0;
            if (32'(q.cfg.ana_sel) < NUM_ANA) begin
               pos_now = {1'b0, ana_pos_i[q.cfg.ana_sel]}; // RQ6
            end
         end
         MODE_NET: begin
            digital = 1'b0;
            pos_now = {1'b0, net_pos_i};
         end
         default: begin
            digital = 1'b0;
         end
      endcase
      span      = q.cfg.last - q.cfg.first + 6'd1;
      d.cfg_err = digital && ((span != need) || (32'(q.cfg.last) > NUM_BI));
      d.pos     = pos_now;
      d.pos_ok  = q.pos_ok || (q.tick_cnt == `TCPC_TICK_W'(2));
      d.pos_err = pos_now > {1'b0, q.cfg.max_pos}; // RQ7
      chg       = q.pos_ok && (pos_now != q.pos);

      // Wishbone classic slave, one wait state
      req   = cyc_i && stb_i;
      d.ack = req && !q.ack;
      wr    = req && we_i && q.ack;
      c_sel_r  = wr && (adr_i == `TCPC_REG_CMD) && sel_i[0] && dat_i[`TCPC_CMD_SEL_RAISE];
      c_sel_l  = wr && (adr_i == `TCPC_REG_CMD) && sel_i[0] && dat_i[`TCPC_CMD_SEL_LOWER];
      c_exec   = wr && (adr_i == `TCPC_REG_CMD) && sel_i[0] && dat_i[`TCPC_CMD_EXECUTE];
      c_cancel = wr && (adr_i == `TCPC_REG_CMD) && sel_i[0] && dat_i[`TCPC_CMD_CANCEL];

      ctrl_rd = {2'd0, q.cfg.max_pos, 2'd0, q.cfg.last, 2'd0, q.cfg.first,
                 1'b0, q.cfg.ana_sel, q.cfg.stop_en, q.cfg.mode};
      stat_rd = {13'd0, q.stop, q.lower, q.raise, 2'd0, q.st, 2'd0, q.cfg_err,
                 q.pos_err, 1'b0, q.pos};
      if (wr) begin
         case (adr_i)
            `TCPC_REG_CTRL: begin
               wv = merge(ctrl_rd, dat_i, sel_i);
               if (wv[2:0] <= 3'(MODE_NET)) begin
                  d.cfg.mode = tcpc_mode_e'(wv[2:0]); // RQ1
               end
               d.cfg.stop_en = wv[`TCPC_CTRL_STOPEN_BIT]; // RQ15
               d.cfg.ana_sel = wv[`TCPC_CTRL_ANA_LSB +: 3];
               if (wv[`TCPC_CTRL_FIRST_LSB +: 6] != 6'd0) begin
                  d.cfg.first = wv[`TCPC_CTRL_FIRST_LSB +: 6];
               end
               if (wv[`TCPC_CTRL_LAST_LSB +: 6] != 6'd0) begin
                  d.cfg.last = wv[`TCPC_CTRL_LAST_LSB +: 6];
               end
               if (wv[`TCPC_CTRL_MAX_LSB +: 6] >= `TCPC_MAX_POS_MIN &&
                   wv[`TCPC_CTRL_MAX_LSB +: 6] <= `TCPC_MAX_POS_MAX) begin
                  d.cfg.max_pos = wv[`TCPC_CTRL_MAX_LSB +: 6]; // RQ7
               end
            end
            `TCPC_REG_RAISE_PW: begin
               d.cfg.raise_pw = clamp_pw(merge(32'(q.cfg.raise_pw), dat_i, sel_i)); // RQ10
            end
            `TCPC_REG_LOWER_PW: begin
               d.cfg.lower_pw = clamp_pw(merge(32'(q.cfg.lower_pw), dat_i, sel_i)); // RQ11
            end
            `TCPC_REG_STOP_PW: begin
               d.cfg.stop_pw = clamp_pw(merge(32'(q.cfg.stop_pw), dat_i, sel_i)); // RQ12
            end
            `TCPC_REG_SEL_TO: begin
               d.cfg.sel_to = clamp_to(merge(32'(q.cfg.sel_to), dat_i, sel_i)); // RQ13
            end
            `TCPC_REG_EXE_TO: begin
               d.cfg.exe_to = clamp_to(merge(32'(q.cfg.exe_to), dat_i, sel_i)); // RQ14
            end
            `TCPC_REG_IRQ_STAT: begin
               irq_clr = dat_i[5:0] & {6{sel_i[0]}};
            end
            `TCPC_REG_IRQ_MASK: begin
               if (sel_i[0]) begin
                  d.irq_mask = dat_i[5:0];
               end
            end
            default: begin
            end
         endcase
      end

      if (req && !q.ack) begin
         case (adr_i)
            `TCPC_REG_CTRL:     d.rdat = ctrl_rd;
            `TCPC_REG_RAISE_PW: d.rdat = 32'(q.cfg.raise_pw);
            `TCPC_REG_LOWER_PW: d.rdat = 32'(q.cfg.lower_pw);
            `TCPC_REG_STOP_PW:  d.rdat = 32'(q.cfg.stop_pw);
            `TCPC_REG_SEL_TO:   d.rdat = 32'(q.cfg.sel_to);
            `TCPC_REG_EXE_TO:   d.rdat = 32'(q.cfg.exe_to);
            `TCPC_REG_STATUS:   d.rdat = stat_rd;
            `TCPC_REG_IRQ_STAT: d.rdat = 32'(q.irq_stat);
            `TCPC_REG_IRQ_MASK: d.rdat = 32'(q.irq_mask);
            default:            d.rdat = 32'd0;
         endcase
      end

      // Runaway: any change not the one expected step of an execute
      runaway = chg && !((q.st == ST_EXEC) && !q.step_seen); // RQ17

      // Select-before-operate sequencer
      case (q.st)
         ST_IDLE: begin
            if (c_exec || (c_sel_r && c_sel_l)) begin
               ev_rej = 1'b1; // RQ9
            end else if (c_sel_r || c_sel_l) begin
               d.st        = ST_SELECTED;
               d.dir_raise = c_sel_r;
               d.phase_cnt = 13'd0;
            end
         end
         ST_SELECTED: begin
            if (tick) begin
               d.phase_cnt = q.phase_cnt + 13'd1;
            end
            if (c_sel_r || c_sel_l) begin
               ev_rej = 1'b1;
            end
            if (c_cancel) begin
               d.st = ST_IDLE;
            end else if (c_exec) begin
               d.st        = ST_EXEC; // RQ9
               d.phase_cnt = 13'd0;
               d.pulse_cnt = 10'd0;
               d.step_seen = 1'b0;
            end else if (q.phase_cnt >= q.cfg.sel_to) begin
               d.st     = ST_IDLE; // RQ13
               ev_selto = 1'b1;
            end
         end
         ST_EXEC: begin
            pulse_act = q.pulse_cnt < (q.dir_raise ? q.cfg.raise_pw : q.cfg.lower_pw);
            if (c_sel_r || c_sel_l || c_exec || c_cancel) begin
               ev_rej = 1'b1; // RQ18
            end
            if (tick) begin
               d.phase_cnt = q.phase_cnt + 13'd1;
               if (pulse_act) begin
                  d.pulse_cnt = q.pulse_cnt + 10'd1;
               end
            end
            if (chg) begin
               d.step_seen = 1'b1;
            end
            if (runaway) begin
               d.st    = ST_IDLE;
               ev_fail = 1'b1;
            end else if (!pulse_act && (q.step_seen || chg)) begin
               d.st    = ST_IDLE;
               ev_done = 1'b1;
            end else if (q.phase_cnt >= q.cfg.exe_to) begin
               d.st    = ST_IDLE; // RQ14
               ev_fail = 1'b1;
            end
         end
         default: begin
            d.st = ST_IDLE;
         end
      endcase
      pulse_act = 1'b0;
      if (d.st == ST_EXEC) begin
         pulse_act = d.pulse_cnt < (d.dir_raise ? d.cfg.raise_pw : d.cfg.lower_pw);
      end
      d.raise = pulse_act && d.dir_raise;  // RQ10 RQ18
      d.lower = pulse_act && !d.dir_raise; // RQ11 RQ18

      // Emergency stop pulse
      if (runaway && q.cfg.stop_en) begin
         d.stop_busy = 1'b1; // RQ16 RQ15
         d.stop_cnt  = 10'd0;
      end else if (q.stop_busy) begin
         if (q.stop_cnt >= q.cfg.stop_pw) begin
            d.stop_busy = 1'b0;
         end else if (tick) begin
            d.stop_cnt = q.stop_cnt + 10'd1;
         end
      end
      d.stop = d.stop_busy && (d.stop_cnt < q.cfg.stop_pw); // RQ12

      // Sticky events; a new event wins over a clear in the same cycle
      events     = {ev_rej, ev_done, ev_fail, ev_selto, runaway, d.pos_err && !q.pos_err};
      d.irq_stat = (q.irq_stat & ~irq_clr) | events;
   end

   ////////////////////////
   // State register

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q               <= '0;
         q.cfg.first     <= `TCPC_RST_FIRST; // RQ8
         q.cfg.last      <= `TCPC_RST_LAST;  // RQ8
         q.cfg.ana_sel   <= `TCPC_RST_ANA;
         q.cfg.max_pos   <= `TCPC_RST_MAX;   // RQ7
         q.cfg.stop_en   <= 1'b0;            // RQ15
         q.cfg.raise_pw  <= `TCPC_RST_PW;
         q.cfg.lower_pw  <= `TCPC_RST_PW;
         q.cfg.stop_pw   <= `TCPC_RST_PW;
         q.cfg.sel_to    <= `TCPC_RST_TO;
         q.cfg.exe_to    <= `TCPC_RST_TO;
      end else begin
         q <= d;
      end
   end

   assign dat_o                   = q.rdat;
   assign ack_o                   = q.ack;
   assign raise_command_output_o  = q.raise;
   assign lower_command_output_o  = q.lower;
   assign emergency_stop_output_o = q.stop;
   assign irq_o                   = |(q.irq_stat & q.irq_mask);

endmodule
`default_nettype wire

/* verif/tcpc_properties.sv */
// Port properties of the tap changer control block.
// Assumes tcpc_top's one clock and synchronous high reset.
`timescale 1ns/100ps
`default_nettype none
`include "tcpc_defines.svh"
module tcpc_properties #(
   parameter int unsigned TICK_CYCLES = 4
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [31:0] dat_i,
   input  wire logic [31:0] dat_o,
   input  wire logic        we_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        ack_o,
   input  wire logic        raise_command_output_o,
   input  wire logic        lower_command_output_o,
   input  wire logic        emergency_stop_output_o,
   input  wire logic        irq_o
);
   logic        exe_w;
   logic [31:0] run_q;

   assign exe_w = cyc_i && stb_i && we_i && ack_o && adr_i == `TCPC_REG_CMD && dat_i[2];

   // Length of the running raise pulse
   always_ff @(posedge clk_i) begin
      if (rst_i || !raise_command_output_o) begin
         run_q <= 32'h0;
      end else begin
         run_q <= run_q + 32'h1;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   ack_single_a: assert property (ack_o |=> !ack_o)
      else $error("ack too long");
   ack_timing_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("ack late");
   reset_quiet_a: assert property ($fell(rst_i) |-> !ack_o && !irq_o && !raise_command_output_o
      && !lower_command_output_o && !emergency_stop_output_o)
      else $error("busy after reset");
   unmapped_zero_a: assert property (ack_o && !$past(we_i) && ($past(adr_i) >= 8'h28
      || $past(adr_i) == `TCPC_REG_CMD) |-> dat_o == 32'h0)
      else $error("read not zero");
   outs_exclusive_a: assert property (!(raise_command_output_o && lower_command_output_o))
      else $error("both drives");
   raise_cause_a: assert property ($rose(raise_command_output_o) |-> $past(exe_w)
      || $past(exe_w, 2))
      else $error("raise uncaused");
   lower_cause_a: assert property ($rose(lower_command_output_o) |-> $past(exe_w)
      || $past(exe_w, 2))
      else $error("lower uncaused");
   raise_bound_a: assert property (run_q <= 1000 * TICK_CYCLES + 2)
      else $error("raise too long");
endmodule

bind tcpc_top tcpc_properties #(.TICK_CYCLES(TICK_CYCLES)) props (
   .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .irq_o(irq_o),
   .raise_command_output_o(raise_command_output_o),
   .lower_command_output_o(lower_command_output_o),
   .emergency_stop_output_o(emergency_stop_output_o));
`default_nettype wire

/* verif/tcpc_tap_model.sv */
// Tap changer model: position contacts, motor steps once per drive pulse.
// Assumes the bench sets code and window; unused inputs toggle.
`timescale 1ns/100ps
`default_nettype none
module tcpc_tap_model (
   input  wire logic        clk_i,
   input  wire logic        raise_i,
   input  wire logic        lower_i,
   input  wire logic [2:0]  mode_i,
   input  wire logic [5:0]  first_i,
   input  wire logic        stuck_i,
   input  wire logic        slip_i,
   input  wire logic        set_i,
   input  wire logic [5:0]  set_val_i,
   output logic      [31:0] bin_o,
   output var int           pos_o
);
   logic        raise_q = 1'b0;
   logic        lower_q = 1'b0;
   logic [31:0] noise_q = 32'h5a5a5a5a;
   logic [12:0] code;

   initial pos_o = 20;

   always @(posedge clk_i) begin
      raise_q <= raise_i;
      lower_q <= lower_i;
      noise_q <= ~{noise_q[30:0], noise_q[31] ^ noise_q[21]};
      if (set_i) begin
         pos_o <= int'(set_val_i);
      end else if (slip_i) begin
         pos_o <= (pos_o < 39) ? pos_o + 1 : pos_o - 1;
      end else if (!stuck_i && raise_q && !raise_i) begin
         pos_o <= pos_o + 1;
      end else if (!stuck_i && lower_q && !lower_i) begin
         pos_o <= pos_o - 1;
      end
   end

   always_comb begin
      case (mode_i)
         3'h0: code = 13'((1 << (pos_o % 10 + 3)) + (pos_o >= 10 ? 1 << (pos_o / 10 - 1) : 0));
         3'h1: code = 13'((pos_o >= 10 ? 1 << (pos_o / 10 + 3) : 0) + pos_o % 10);
         default: code = 13'(pos_o);
      endcase
      bin_o = noise_q;
      for (int i = 0; i < 13; i++) begin
         if (i < (mode_i == 3'h0 ? 13 : mode_i == 3'h1 ? 7 : 6) && first_i + i <= 32) begin
            bin_o[first_i - 1 + i] = code[i];
         end
      end
   end
endmodule
`default_nettype wire

/* verif/tap_changer_position_control_test.sv */
// Self-checking bench of the tap changer control block.
// Assumes tcpc_top, tcpc_tap_model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module tap_changer_position_control_test;
   localparam int T = 4;
   logic            clk, ack, raise, lower, stop, irq;
   logic            rst = 1'b1;
   logic            we = 1'b0;
   logic            cyc = 1'b0;
   logic            stb = 1'b0;
   logic            stuck = 1'b0;
   logic            slip = 1'b0;
   logic            pset = 1'b0;
   logic [7:0]      adr = 8'h0;
   logic [31:0]     wd = 32'h0;
   logic [31:0]     rdat, bin;
   logic [5:0][5:0] ana = '0;
   logic [5:0]      net = 6'h0;
   logic [2:0]      pm = 3'h0;
   logic [5:0]      pf = 6'h1;
   logic [5:0]      pv = 6'h0;
   int              pos, miscompares, checks_done;
   logic [31:0]     rv [11] = '{32'h270d0100, 20, 20, 20, 3000, 3000, 0, 20, 0, 0, 0};
   logic [7:0]      ia [6] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h10, 8'h14};
   logic [31:0]     iw [6] = '{32'h27060107, 32'h00060102, 32'h28060102, 2000, 5, 7000};
   logic [31:0]     ie [6] = '{32'h27060102, 32'h27060102, 32'h27060102, 1000, 1000, 6000};

   tcpc_top #(.TICK_CYCLES(T)) uut (
      .clk_i(clk), .rst_i(rst), .adr_i(adr), .dat_i(wd), .dat_o(rdat), .we_i(we),
      .sel_i(4'hf), .cyc_i(cyc), .stb_i(stb), .ack_o(ack), .bin_in_i(bin), .ana_pos_i(ana),
      .net_pos_i(net), .raise_command_output_o(raise), .lower_command_output_o(lower),
      .emergency_stop_output_o(stop), .irq_o(irq));

   tcpc_tap_model tap (
      .clk_i(clk), .raise_i(raise), .lower_i(lower), .mode_i(pm), .first_i(pf),
      .stuck_i(stuck), .slip_i(slip), .set_i(pset), .set_val_i(pv), .bin_o(bin), .pos_o(pos));

   ////////////////////////
   task automatic complete_run();
      if (miscompares == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wb(input logic [7:0] a, input logic [31:0] d, input logic w,
                     output logic [31:0] r);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      wd  <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 40);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      @(posedge clk);
      if (n >= 40) begin
         check("bus answer", 32'h0, 32'h1);
         complete_run();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      wb(a, d, 1'b1, r);
   endtask

   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      wb(a, 32'h0, 1'b0, r);
      check(nm, r, e);
   endtask

   task automatic cfg(input int m, en, f, mx, ch, p);
      int w;
      w = (m == 0) ? 13 : (m == 1) ? 7 : 6;
      @(posedge clk);
      pm      <= 3'(m);
      pf      <= 6'(f);
      pv      <= 6'(p);
      pset    <= 1'b1;
      net     <= 6'(p);
      ana[ch] <= 6'(p);
      @(posedge clk);
      pset <= 1'b0;
      wr(8'h00, 32'(m | en << 3 | ch << 4 | f << 8 | (f + w - 1) << 16 | mx << 24));
   endtask

   task automatic wait_out(input int d, output int len);
      int n;
      n = 0;
      len = 0;
      while ((d == 2 ? stop : d ? lower : raise) !== 1'b1 && n < 30) begin
         @(posedge clk);
         n++;
      end
      while ((d == 2 ? stop : d ? lower : raise) === 1'b1 && len < 200) begin
         @(posedge clk);
         len++;
      end
   endtask

   ////////////////////////
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   initial begin
      int n, len, p, mx;
      miscompares = 0;
      checks_done = 0;
      void'($urandom(53));
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 11; i++) begin
         rchk("reset value", 8'(4 * i), rv[i]);
      end
      // Every source mode, random window, position and maximum
      for (int k = 0; k < 20; k++) begin
         ana <= 36'($urandom);
         p = $urandom % 40;
         mx = 1 + $urandom % 39;
         cfg(k % 5, 0, 1 + $urandom % 20, mx, $urandom % 6, p);
         repeat (5) @(posedge clk);
         rchk("position", 8'h1c, 32'(p) | (p > mx ? 32'h100 : 32'h0));
      end
      cfg(2, 0, 1, 39, 0, 20);
      for (int i = 0; i < 6; i++) begin
         wr(ia[i], iw[i]);
         rchk("refused value", ia[i], ie[i]);
      end
      for (int i = 0; i < 3; i++) begin
         wr(8'(4 + 4 * i), 32'd2);
      end
      // Raise then lower under select-before-operate
      for (int d = 0; d < 2; d++) begin
         wr(8'h20, 32'h3f);
         p = pos;
         wr(8'h18, 32'h1 << d);
         rchk("selected", 8'h1c, 32'(p) | 32'h1000);
         wr(8'h18, 32'h4);
         wait_out(d, len);
         check("pulse length", 32'(len >= T - 2 && len <= 2 * T + 1), 32'h1);
         repeat (8) @(posedge clk);
         rchk("stepped", 8'h1c, 32'(d ? p - 1 : p + 1));
         rchk("done flag", 8'h20, 32'h10);
      end
      p = pos;
      wr(8'h20, 32'h3f);
      wr(8'h18, 32'h4);
      wr(8'h18, 32'h3);
      wr(8'h18, 32'h1);
      wr(8'h18, 32'h2);
      rchk("double select", 8'h1c, 32'(p) | 32'h1000);
      wr(8'h18, 32'h8);
      rchk("rejects", 8'h20, 32'h20);
      wr(8'h04, 32'd20);
      wr(8'h18, 32'h1);
      wr(8'h18, 32'h4);
      wr(8'h18, 32'h2);
      rchk("busy pulse", 8'h1c, 32'(p) | 32'h12000);
      check("irq masked", 32'(irq), 32'h0);
      wr(8'h24, 32'h20);
      check("irq raised", 32'(irq), 32'h1);
      wr(8'h20, 32'h20);
      check("irq cleared", 32'(irq), 32'h0);
      repeat (100) @(posedge clk);
      rchk("long step", 8'h1c, 32'(p + 1));
      // Runaway step with stop disabled, then enabled
      for (int en = 0; en < 2; en++) begin
         cfg(2, en, 1, 39, 0, pos);
         wr(8'h20, 32'h3f);
         @(posedge clk);
         slip <= 1'b1;
         @(posedge clk);
         slip <= 1'b0;
         wait_out(2, len);
         check("stop pulse", 32'(len >= T - 2 && len <= 2 * T + 1), 32'(en));
         rchk("runaway flag", 8'h20, 32'h2);
      end
      // Select and execute timeouts at their minimum
      stuck <= 1'b1;
      wr(8'h14, 32'd1000);
      for (int t = 0; t < 2; t++) begin
         wr(8'h20, 32'h3f);
         wr(8'h24, 32'h4 << t);
         wr(8'h18, 32'h1);
         if (t == 1) begin
            wr(8'h18, 32'h4);
         end
         n = 0;
         while (irq !== 1'b1 && n < 4200) begin
            @(posedge clk);
            n++;
         end
         check("timeout", 32'(n > 3980 && n < 4100), 32'h1);
      end
      complete_run();
   end
endmodule
`default_nettype wire
